// ### hdl/dra_pkg.sv
// constants and types of the dynamic phase alignment receive realigner
// How it works
// - forwarded clock multiplied by W, but ph stops at PH_LAST, so only the first of W bits per source period is sampled
// - eight phases; channel locks nearest data phase
// - phase step is one eighth bit period
// - phase choice automatic, continuous, per channel
// - every data transition seen at a phase tick measures and corrects drift
// - four deep, J wide synchronizer FIFO
// - FIFO clocks share frequency; no flags needed
// - aligned phase does not fix word boundary
// - realignment per channel on parallel data
// - each request rising edge shifts one bit
// - unused realigner only adds register latency
// - request comes from pin or logic
// - word width 8 or 10, slips wrap
// - counter wraps past n-1, word from third register
package dra_pkg;
  // link timing figures
  localparam int LINK_RATE_MBPS = 1000;
  localparam int RESOLUTION_PS = 125;
  localparam int BIT_PERIOD_PS = 1000000 / LINK_RATE_MBPS;
  localparam int PHASES = BIT_PERIOD_PS / RESOLUTION_PS;
  localparam int PH_W = $clog2(PHASES);
  localparam logic [PH_W-1:0] PH_CENTER = PH_W'(PHASES / 2);
  localparam logic [PH_W-1:0] PH_ONE = PH_W'(1);
  // source period measurement width in system clocks
  localparam int PER_W = 8;
  localparam logic [PER_W-1:0] PER_MAX = {PER_W{1'b1}};
  // synchronizer FIFO layout
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_AW = 2;
  localparam logic [FIFO_AW-1:0] WR_START = 2'h2;
  localparam logic [FIFO_AW-1:0] FIFO_GAP = 2'h3;
  // global read enable trails the parallel write enable by this
  localparam int RD_LAG = 2;
  // lock state machine
  typedef enum logic [1:0] {
    DRA_HUNT = 2'b00,
    DRA_LOCK = 2'b01
  } dra_lock_e;
endpackage

// ### hdl/dra_receive_realigner.sv
// phase alignment, deserializer, synchronizer FIFO and bit-slip realigner
`timescale 1ns/1ns

// small valid/ready buffer that absorbs receiver stalls
module dra_buf #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0] cnt, next_cnt;
  logic push, pop;
  // handshakes and pointer updates
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wp = push ? ((wp == LAST) ? '0 : wp + 1'b1) : wp;
    next_rp = pop ? ((rp == LAST) ? '0 : rp + 1'b1) : rp;
    next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  assign in_ready = (cnt != CNT_FULL);
  assign out_valid = (cnt != '0);
  assign out_data = mem[rp];
  // storage and pointers
  always_ff @(posedge clk) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
      if (push) begin
        mem[wp] <= in_data;
      end
    end
  end
endmodule

module dra_receive_realigner
  import dra_pkg::*;
#(
  parameter int W = 1,
  parameter int J = 10,
  parameter int LOCK_HITS = 16
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic SRC_CLK,
  input wire logic SER_DATA,
  input wire logic SLIP_REQ,
  output logic [J-1:0] OUT_DATA,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic LOCKED,
  output logic [PH_W-1:0] PHASE_SEL
);
  localparam int CW = $clog2(J);
  localparam logic [PER_W-1:0] STEP = PER_W'(W * PHASES);
  localparam logic [CW-1:0] CNT_LAST = CW'(J - 1);
  localparam logic [CW:0] J_SH = (CW+1)'(J);
  localparam logic [7:0] HITS_LAST = 8'(LOCK_HITS - 1);
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(PHASES - 1); // no wrap
  // elaboration checks
  if (!(J == 8 || J == 10)) begin : g_bad_j
    $error("word width must be 8 or 10");
  end
  if (W < 1 || W * PHASES > 127) begin : g_bad_w
    $error("multiplier out of range");
  end
  if (LOCK_HITS < 1 || LOCK_HITS > 256) begin : g_bad_hits
    $error("lock hit count out of range");
  end
  // pin synchronizers
  logic src_s1, src_s2, src_s3;
  logic dat_s1, dat_s2;
  logic slp_s1, slp_s2;
  always_ff @(posedge MCLK) begin
    if (RST) begin
      {src_s1, src_s2, src_s3} <= 3'h0;
      {dat_s1, dat_s2} <= 2'h0;
      {slp_s1, slp_s2} <= 2'h0;
    end else begin
      src_s1 <= SRC_CLK;
      src_s2 <= src_s1;
      src_s3 <= src_s2;
      dat_s1 <= SER_DATA;
      dat_s2 <= dat_s1;
      slp_s1 <= SLIP_REQ;
      slp_s2 <= slp_s1;
    end
  end
  logic src_rise;
  assign src_rise = src_s2 && !src_s3;
  // clock multiplier: period meter and eighth-bit tick generator
  logic [PER_W-1:0] per_cnt, per, acc;
  logic [PER_W-1:0] next_per_cnt, next_per, next_acc;
  logic [PH_W-1:0] ph, next_ph;
  logic tick, next_tick;
  logic [PER_W:0] sum;
  always_comb begin
    next_per_cnt = (per_cnt == PER_MAX) ? per_cnt : per_cnt + 1'b1;
    next_per = per;
    sum = {1'b0, acc} + {1'b0, STEP};
    next_acc = acc;
    next_ph = ph;
    next_tick = 1'b0;
    if (src_rise) begin
      next_per_cnt = '0;
      next_per = per_cnt;
      next_acc = '0;
      next_ph = '0;
      next_tick = 1'b1;
    end else if (per != '0 && ph != PH_LAST && sum >= {1'b0, per}) begin
      next_acc = PER_W'(sum - {1'b0, per});
      next_ph = ph + PH_ONE;
      next_tick = 1'b1;
    end else if (per != '0 && ph != PH_LAST) begin
      next_acc = PER_W'(sum);
    end
  end
  always_ff @(posedge MCLK) begin
    if (RST) begin
      per_cnt <= '0;
      per <= '0;
      acc <= '0;
      ph <= '0;
      tick <= 1'b0;
    end else begin
      per_cnt <= next_per_cnt;
      per <= next_per;
      acc <= next_acc;
      ph <= next_ph;
      tick <= next_tick;
    end
  end
  // phase detector and selector, lock tracking
  logic prev_samp, next_prev_samp;
  logic [PH_W-1:0] sel, next_sel, target, diff;
  logic [7:0] hits, next_hits;
  dra_lock_e lst, next_lst;
  logic edge_seen, near;
  always_comb begin
    edge_seen = tick && (dat_s2 != prev_samp);
    target = ph + PH_CENTER;
    diff = target - sel;
    near = (diff == '0) || (diff == PH_ONE) || (diff == -PH_ONE); // one step
    next_prev_samp = tick ? dat_s2 : prev_samp;
    next_sel = sel;
    next_hits = hits;
    next_lst = lst;
    if (edge_seen && diff != '0) begin
      // one eighth-bit step toward the eye centre
      next_sel = (diff < PH_CENTER) ? sel + PH_ONE : sel - PH_ONE;
    end
    case (lst)
      DRA_HUNT: begin
        if (edge_seen && near) begin
          next_hits = hits + 1'b1;
          if (hits == HITS_LAST) begin
            next_lst = DRA_LOCK;
          end
        end else if (edge_seen) begin
          next_hits = '0;
        end
      end
      DRA_LOCK: begin
        if (edge_seen && !near) begin
          next_lst = DRA_HUNT;
          next_hits = '0;
        end
      end
      default: begin
        next_lst = DRA_HUNT;
        next_hits = '0;
      end
    endcase
  end
  always_ff @(posedge MCLK) begin
    if (RST) begin
      prev_samp <= 1'b0;
      sel <= '0;
      hits <= '0;
      lst <= DRA_HUNT;
    end else begin
      prev_samp <= next_prev_samp;
      sel <= next_sel;
      hits <= next_hits;
      lst <= next_lst;
    end
  end
  assign LOCKED = (lst == DRA_LOCK);
  assign PHASE_SEL = sel;
  // deserializer on the selected phase; word strobe is the parallel clock
  logic [J-1:0] shreg, next_shreg;
  logic [CW-1:0] bcnt, next_bcnt;
  logic par_en, next_par_en;
  always_comb begin
    next_shreg = shreg;
    next_bcnt = bcnt;
    next_par_en = 1'b0;
    if (tick && ph == sel) begin
      next_shreg = {dat_s2, shreg[J-1:1]};
      next_bcnt = (bcnt == CNT_LAST) ? '0 : bcnt + 1'b1;
      next_par_en = (bcnt == CNT_LAST);
    end
  end
  always_ff @(posedge MCLK) begin
    if (RST) begin
      shreg <= '0;
      bcnt <= '0;
      par_en <= 1'b0;
    end else begin
      shreg <= next_shreg;
      bcnt <= next_bcnt;
      par_en <= next_par_en;
    end
  end
  // synchronizer FIFO, written on parallel, read on global read clock
  logic [J-1:0] fifo_mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wr, rd, next_wr, next_rd;
  logic [RD_LAG-1:0] lag, next_lag;
  logic global_read_clock;
  always_comb begin
    next_lag = {lag[RD_LAG-2:0], par_en};
    next_wr = par_en ? wr + 1'b1 : wr;
    next_rd = global_read_clock ? rd + 1'b1 : rd;
  end
  assign global_read_clock = lag[RD_LAG-1];
  always_ff @(posedge MCLK) begin
    if (RST) begin
      lag <= '0;
      wr <= WR_START;
      rd <= '0;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifo_mem[i] <= '0;
      end
    end else begin
      lag <= next_lag;
      wr <= next_wr;
      rd <= next_rd;
      if (par_en) begin
        fifo_mem[wr] <= shreg;
      end
    end
  end
  // bit-slip realigner, always in the data path
  logic [J-1:0] reg2, reg3, next_reg2, next_reg3;
  logic [J-1:0] word, next_word;
  logic [CW-1:0] cnt, next_cnt;
  logic slip_prev, next_slip_prev, pend, next_pend, slip_rise;
  logic push, next_push, buf_ready, adv;
  logic [2*J-1:0] pair;
  logic [CW:0] sh;
  always_comb begin
    adv = global_read_clock && buf_ready;
    slip_rise = par_en && slp_s2 && !slip_prev;
    next_slip_prev = par_en ? slp_s2 : slip_prev;
    next_reg2 = reg2;
    next_reg3 = reg3;
    next_cnt = cnt;
    next_pend = pend;
    if (adv) begin
      next_reg2 = reg3;
      next_reg3 = fifo_mem[rd];
      if (pend) begin
        next_cnt = (cnt == CNT_LAST) ? '0 : cnt + 1'b1;
        next_pend = 1'b0;
      end
    end
    if (slip_rise) begin
      next_pend = 1'b1;
    end
    // window of J bits ending at the slip count; zero count is reg3
    pair = {next_reg3, next_reg2};
    sh = J_SH - (CW+1)'(next_cnt);
    next_word = adv ? J'(pair >> sh) : word;
    next_push = adv;
  end
  always_ff @(posedge MCLK) begin
    if (RST) begin
      reg2 <= '0;
      reg3 <= '0;
      word <= '0;
      cnt <= '0;
      slip_prev <= 1'b0;
      pend <= 1'b0;
      push <= 1'b0;
    end else begin
      reg2 <= next_reg2;
      reg3 <= next_reg3;
      word <= next_word;
      cnt <= next_cnt;
      slip_prev <= next_slip_prev;
      pend <= next_pend;
      push <= next_push;
    end
  end
  // output buffer toward the user
  dra_buf #(.WIDTH(J), .DEPTH(2)) u_buf (
    .clk(MCLK),
    .rst(RST),
    .in_data(word),
    .in_valid(push),
    .in_ready(buf_ready),
    .out_data(OUT_DATA),
    .out_valid(OUT_VALID),
    .out_ready(OUT_READY)
  );
  // checks
  sequence s_take;
    adv && pend;
  endsequence
  sequence s_hold;
    adv && !pend;
  endsequence
  tick_start_a: assert property (@(posedge MCLK) disable iff (RST)
    src_rise |=> tick && ph == '0)
    else $error("no phase tick at source edge");
  phase_step_a: assert property (@(posedge MCLK) disable iff (RST)
    $changed(sel) |-> (sel - $past(sel) == PH_ONE) ||
      ($past(sel) - sel == PH_ONE))
    else $error("phase moved more than one step");
  drift_fix_a: assert property (@(posedge MCLK) disable iff (RST)
    edge_seen && diff != '0 |=> sel != $past(sel))
    else $error("phase error not corrected");
  lock_entry_a: assert property (@(posedge MCLK) disable iff (RST)
    $rose(LOCKED) |-> $past(hits) == HITS_LAST)
    else $error("lock without enough hits");
  fifo_lag_a: assert property (@(posedge MCLK) disable iff (RST)
    par_en |-> ##2 global_read_clock)
    else $error("read clock not two cycles behind");
  fifo_gap_a: assert property (@(posedge MCLK) disable iff (RST)
    global_read_clock |-> wr - rd == FIFO_GAP)
    else $error("fifo pointer gap wrong");
  slip_one_a: assert property (@(posedge MCLK) disable iff (RST)
    s_take and (cnt != CNT_LAST) |=> cnt == $past(cnt) + 1'b1)
    else $error("slip did not advance by one");
  slip_wrap_a: assert property (@(posedge MCLK) disable iff (RST)
    s_take and (cnt == CNT_LAST) |=> cnt == '0 && word == reg3)
    else $error("wrap not taken from third register");
  no_slip_a: assert property (@(posedge MCLK) disable iff (RST)
    s_hold and (cnt == '0) |=> word == reg3 && cnt == $past(cnt))
    else $error("data changed without slip");
  edge_once_a: assert property (@(posedge MCLK) disable iff (RST)
    par_en && slp_s2 && slip_prev |=> !$rose(pend))
    else $error("held request slipped again");
endmodule

// ### hdl/dummy_none.sv
// no further logic; kept empty
`timescale 1ns/1ns

// ### tb/dra_tx_model.sv
// partner: remote serial sender plus slip pulse generator
`timescale 1ns/1ns
module dra_tx_model #(
  parameter int J = 10
) (
  input wire logic [J-1:0] word,
  input wire logic go,
  input wire logic hold,
  output logic src_clk = 1'b0,
  output logic ser_data = 1'b0,
  output logic slip_req = 1'b0,
  output logic busy
);
  int bit_i = 0;
  int cnt = 0;
  // free running source clock, fixed 125 ns period
  always begin
    #62 src_clk = 1'b1;
    #63 src_clk = 1'b0;
  end
  // one bit per period, lsb first, word repeated
  always @(negedge src_clk) begin
    ser_data <= word[bit_i];
    bit_i <= (bit_i == J - 1) ? 0 : bit_i + 1;
  end
  // pulse high two word periods, low four before the next
  always @(negedge src_clk) begin
    if (bit_i == 0) begin
      if (cnt != 0) cnt <= cnt - 1;
      else if (go) cnt <= 5;
      slip_req <= (cnt >= 4) || hold;
    end
  end
  assign busy = (cnt != 0);
endmodule

// ### tb/test_dra_receive_realigner.sv
// bench for the receive realigner with serial partner
`timescale 1ns/1ns
module test_dra_receive_realigner import dra_pkg::*;;
  localparam int J = 10;
  localparam logic [J-1:0] TRAIN = 10'h155;
  localparam logic [J-1:0] DATA = 10'h0f3;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic OUT_READY = 1'b1;
  logic [J-1:0] word = TRAIN;
  logic go = 1'b0;
  logic hold = 1'b0;
  logic SRC_CLK, SER_DATA, SLIP_REQ, OUT_VALID, LOCKED, busy;
  logic [J-1:0] OUT_DATA;
  logic [J-1:0] a, b;
  logic [PH_W-1:0] PHASE_SEL;
  int bad_count = 0;
  int n_checks = 0;
  // 100 MHz system clock
  always #5 MCLK = ~MCLK;
  dra_receive_realigner #(.W(1), .J(J), .LOCK_HITS(4)) i_dra_receive_realigner (
    .MCLK(MCLK), .RST(RST), .SRC_CLK(SRC_CLK), .SER_DATA(SER_DATA),
    .SLIP_REQ(SLIP_REQ), .OUT_DATA(OUT_DATA), .OUT_VALID(OUT_VALID),
    .OUT_READY(OUT_READY), .LOCKED(LOCKED), .PHASE_SEL(PHASE_SEL));
  dra_tx_model #(.J(J)) i_dra_tx_model (.word(word), .go(go),
    .hold(hold), .src_clk(SRC_CLK), .ser_data(SER_DATA),
    .slip_req(SLIP_REQ), .busy(busy));
  // verdict and end of run
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic timeout(string name);
    bad_count++;
    $display("ERROR %s exp done got timeout", name);
    conclude();
  endtask
  task automatic chk(string name, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s exp %h got %h", name, e, g);
    end
  endtask
  function automatic logic [J-1:0] rotl(logic [J-1:0] v, int k);
    return (v << k) | (v >> (J - k));
  endfunction
  // take one word where settled, popped at the next edge
  task automatic get_word(output logic [J-1:0] w);
    int i;
    @(negedge MCLK);
    for (i = 0; i < 400 && OUT_VALID !== 1'b1; i++) @(negedge MCLK);
    if (OUT_VALID !== 1'b1) timeout("out_valid");
    w = OUT_DATA;
    @(posedge MCLK);
  endtask
  // one slip pulse through the partner, waits for it to finish
  task automatic slip();
    int i;
    @(posedge MCLK) go <= 1'b1;
    for (i = 0; i < 1000 && !busy; i++) @(posedge MCLK);
    if (!busy) timeout("slip start");
    go <= 1'b0;
    for (i = 0; i < 1000 && busy; i++) @(posedge MCLK);
    if (busy) timeout("slip end");
    repeat (2) get_word(a);
  endtask
  task automatic t_lock();
    int i;
    for (i = 0; i < 30000 && LOCKED !== 1'b1; i++) @(posedge MCLK);
    chk("locked", 1, LOCKED);
  endtask
  task automatic t_stream();
    int k;
    logic hit;
    @(posedge MCLK) word <= DATA;
    repeat (6) get_word(a);
    get_word(b);
    chk("steady word", a, b);
    hit = 0;
    for (k = 0; k < J; k++) hit |= (b === rotl(DATA, k));
    chk("rotated word", 1, hit);
  endtask
  task automatic t_walk();
    int k;
    logic [J-1:0] base;
    get_word(base);
    for (k = 1; k <= J; k++) begin
      slip();
      get_word(b);
      chk("slip step", rotl(base, k), b);
    end
  endtask
  task automatic t_hold();
    get_word(b);
    @(posedge MCLK) hold <= 1'b1;
    repeat (6) get_word(a);
    @(posedge MCLK) hold <= 1'b0;
    repeat (4) get_word(a);
    chk("held request", rotl(b, 1), a);
  endtask
  task automatic t_align();
    int k;
    get_word(b);
    for (k = 0; k < J && b !== DATA; k++) begin
      slip();
      get_word(b);
    end
    chk("aligned", DATA, b);
  endtask
  task automatic t_stall();
    @(posedge MCLK) OUT_READY <= 1'b0;
    repeat (400) @(posedge MCLK);
    @(negedge MCLK);
    a = OUT_DATA;
    chk("stall valid", 1, OUT_VALID);
    repeat (300) @(posedge MCLK);
    @(negedge MCLK);
    chk("stall data", a, OUT_DATA);
    @(posedge MCLK) OUT_READY <= 1'b1;
    get_word(b);
    chk("drained", a, b);
    repeat (3) get_word(b);
    chk("after stall", DATA, b);
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge MCLK);
    chk("rst valid", 0, OUT_VALID);
    chk("rst locked", 0, LOCKED);
    chk("rst phase", 0, PHASE_SEL);
    chk("rst data", 0, OUT_DATA);
    RST <= 1'b0;
    t_lock();
    t_stream();
    t_walk();
    t_hold();
    t_align();
    t_stall();
    conclude();
  end
endmodule
